// File: hdl/spb_pkg.sv
package spb_pkg;

  // register offsets on the byte-wide register port
  localparam logic [6:0] SPB_ADDR_IDENT = 7'h00;
  localparam logic [6:0] SPB_ADDR_REF_IRQ_STAT = 7'h02;
  localparam logic [6:0] SPB_ADDR_PLL_IRQ_STAT = 7'h03;
  localparam logic [6:0] SPB_ADDR_MON_FAIL = 7'h05;
  localparam logic [6:0] SPB_ADDR_REF_IRQ_MASK = 7'h09;
  localparam logic [6:0] SPB_ADDR_PLL_IRQ_MASK = 7'h0A;
  localparam logic [6:0] SPB_ADDR_MON_FAIL_MASK = 7'h0C;
  localparam logic [6:0] SPB_ADDR_FREQ_DETECT = 7'h10;
  localparam logic [6:0] SPB_ADDR_LOOP_BW = 7'h1D;
  localparam logic [6:0] SPB_ADDR_HOLD_MASK = 7'h21;
  localparam logic [6:0] SPB_ADDR_LOCK_STAT = 7'h28;
  localparam logic [6:0] SPB_ADDR_PHASE_LOW = 7'h40;
  localparam logic [6:0] SPB_ADDR_PHASE_MID = 7'h41;
  localparam logic [6:0] SPB_ADDR_PHASE_HIGH = 7'h42;
  localparam logic [6:0] SPB_ADDR_SYNTH_EN = 7'h50;
  localparam logic [6:0] SPB_ADDR_SYNTH_RUN = 7'h51;
  localparam logic [6:0] SPB_ADDR_SYNTH_FREQ = 7'h52;
  localparam logic [6:0] SPB_ADDR_SYNTH_COARSE = 7'h53;
  localparam logic [6:0] SPB_ADDR_SYNTH_FINE = 7'h55;
  localparam logic [6:0] SPB_ADDR_DIFF_EN = 7'h60;
  localparam logic [6:0] SPB_ADDR_DIFF_FREQ = 7'h61;
  localparam logic [6:0] SPB_ADDR_SRC_MODE = 7'h65;
  localparam logic [6:0] SPB_ADDR_MULT_LOW = 7'h67;
  localparam logic [6:0] SPB_ADDR_MULT_HIGH = 7'h68;
  localparam logic [6:0] SPB_ADDR_SCM_LOW = 7'h69;

  // field positions and widths
  localparam int SPB_PHASE_W = 22;
  localparam int SPB_MULT_W = 14;
  localparam int SPB_MON_SCM = 0;
  localparam int SPB_MON_CFM = 1;
  localparam int SPB_MON_PFM = 2;
  localparam int SPB_PLL_LOCKED = 0;
  localparam int SPB_PLL_LOCK_LOST = 1;
  localparam int SPB_PLL_HOLD_IN = 2;
  localparam int SPB_PLL_HOLD_OUT = 3;
  localparam int SPB_STAT_LOCK = 0;
  localparam int SPB_STAT_HOLD = 1;

  // values after reset
  localparam logic [7:0] SPB_RST_BYTE = 8'h00;
  localparam logic [7:0] SPB_RST_IRQ_MASK = 8'h00;
  localparam logic [21:0] SPB_RST_PHASE = 22'h000000;
  localparam logic [13:0] SPB_RST_MULT = 14'h0000;

  // identity fields; both values arbitrary
  localparam logic [4:0] SPB_CHIP_ID = 5'h0A;
  localparam logic [1:0] SPB_CHIP_REV = 2'h0;

endpackage : spb_pkg

// File: hdl/spb_reg_bank.sv
// Notes on behaviour
// - frame phase offset is 22 bits over three bytes, low, middle, upper
// - offset zero reads chip identity and revision, read only
// - reference failure status register reports input failure, read only
// - pll interrupt status and monitor failure bits are sticky, read only
// - masks for reference failure and pll interrupts gate the interrupt
// - each monitor failure indicator can be masked on its own
// - detected input frequency is readable status
// - loop filter bandwidth comes from a writable control register
// - masked monitor failures do not request automatic holdover
// - lock and holdover state readable in one status register
// - block enable register and separate run register drive synthesiser
// - run register value is driven out unchanged on synth_run_o
// - synthesiser output frequency comes from a writable select register
// - coarse phase register and separate fine offset register for synthesiser
// - differential output enable and frequency select registers
// - source mode picks auto detect, custom config a or b
// - custom a multiplier is 14 bits, low byte then upper six bits
// - custom a single-cycle lower limit is a writable register
// - reading a sticky register clears its bits
// - multi-byte read value is frozen by its low-byte read and stays stable until the next low-byte read
// - written multi-byte value takes effect when its top byte is written
// - interrupt output goes low on input failure or lock/holdover change
`timescale 1ns/1ps
`default_nettype none

module spb_reg_bank (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic ref_fail_i,
  input wire logic scm_fail_i,
  input wire logic cfm_fail_i,
  input wire logic pfm_fail_i,
  input wire logic [7:0] freq_detected_i,
  input wire logic pll_locked_i,
  input wire logic pll_holdover_i,
  output logic irq_n_o,
  output logic holdover_req_o,
  output logic [7:0] loop_bandwidth_o,
  output logic [21:0] frame_phase_offset_o,
  output logic [7:0] synth_block_enable_o,
  output logic [7:0] synth_run_o,
  output logic [7:0] synth_freq_o,
  output logic [7:0] synth_phase_coarse_o,
  output logic [7:0] synth_phase_fine_o,
  output logic [7:0] diff_out_enable_o,
  output logic [7:0] diff_out_freq_o,
  output logic [7:0] freq_source_mode_o,
  output logic [13:0] custom_a_multiplier_o,
  output logic [7:0] custom_a_single_cycle_low_o
);
  import spb_pkg::*;

  typedef struct packed {
    logic rst_done;
    logic [7:0] rdata;
    logic rvalid;
    logic lock_q;
    logic hold_q;
    logic [7:0] pll_sticky;
    logic [7:0] mon_sticky;
    logic [7:0] ref_irq_mask;
    logic [7:0] pll_irq_mask;
    logic [7:0] mon_mask;
    logic [7:0] loop_bw;
    logic [7:0] hold_mask;
    logic [21:0] phase;
    logic [15:0] phase_stage;
    logic [21:0] phase_shadow;
    logic [7:0] synth_en;
    logic [7:0] synth_run;
    logic [7:0] synth_freq;
    logic [7:0] synth_coarse;
    logic [7:0] synth_fine;
    logic [7:0] diff_en;
    logic [7:0] diff_freq;
    logic [7:0] src_mode;
    logic [13:0] mult;
    logic [7:0] mult_stage;
    logic [13:0] mult_shadow;
    logic [7:0] scm_low;
    logic irq_n;
    logic hold_req;
  } spb_state_t;

  localparam spb_state_t SPB_STATE_RST = '{
    rst_done: 1'b0,
    rdata: SPB_RST_BYTE,
    rvalid: 1'b0,
    lock_q: 1'b0,
    hold_q: 1'b0,
    pll_sticky: SPB_RST_BYTE,
    mon_sticky: SPB_RST_BYTE,
    ref_irq_mask: SPB_RST_IRQ_MASK,
    pll_irq_mask: SPB_RST_IRQ_MASK,
    mon_mask: SPB_RST_BYTE,
    loop_bw: SPB_RST_BYTE,
    hold_mask: SPB_RST_BYTE,
    phase: SPB_RST_PHASE,
    phase_stage: 16'h0000,
    phase_shadow: SPB_RST_PHASE,
    synth_en: SPB_RST_BYTE,
    synth_run: SPB_RST_BYTE,
    synth_freq: SPB_RST_BYTE,
    synth_coarse: SPB_RST_BYTE,
    synth_fine: SPB_RST_BYTE,
    diff_en: SPB_RST_BYTE,
    diff_freq: SPB_RST_BYTE,
    src_mode: SPB_RST_BYTE,
    mult: SPB_RST_MULT,
    mult_stage: SPB_RST_BYTE,
    mult_shadow: SPB_RST_MULT,
    scm_low: SPB_RST_BYTE,
    irq_n: 1'b1,
    hold_req: 1'b0
  };

  // set wins over a clear that lands in the same cycle
  function automatic logic [7:0] sticky_update(input logic [7:0] cur,
                                               input logic [7:0] set,
                                               input logic clr);
    logic [7:0] res;
    res = clr ? set : (cur | set);
    return res;
  endfunction : sticky_update

  function automatic logic wr_hit(input logic wr, input logic [6:0] a,
                                  input logic [6:0] target);
    logic hit;
    hit = wr && (a == target);
    return hit;
  endfunction : wr_hit

  function automatic logic rd_hit(input logic rd, input logic [6:0] a,
                                  input logic [6:0] target);
    logic hit;
    hit = rd && (a == target);
    return hit;
  endfunction : rd_hit

  logic rst_meta;
  logic rst_sync_n;
  spb_state_t s;
  spb_state_t next_s;
  logic [7:0] pll_set;
  logic [7:0] mon_set;
  logic [7:0] pll_sticky_nx;
  logic [7:0] rd_byte;

  // reset arrives asynchronously, leaves in step with the clock
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_comb begin
    next_s = s;
    next_s.rst_done = 1'b1;

    // lock and holdover transitions become sticky events
    pll_set = 8'h00;
    pll_set[SPB_PLL_LOCKED] = pll_locked_i && !s.lock_q;
    pll_set[SPB_PLL_LOCK_LOST] = !pll_locked_i && s.lock_q;
    pll_set[SPB_PLL_HOLD_IN] = pll_holdover_i && !s.hold_q;
    pll_set[SPB_PLL_HOLD_OUT] = !pll_holdover_i && s.hold_q;
    next_s.lock_q = pll_locked_i;
    next_s.hold_q = pll_holdover_i;

    // a masked monitor leaves no trace in the failure register
    mon_set = 8'h00;
    mon_set[SPB_MON_SCM] = scm_fail_i && !s.mon_mask[SPB_MON_SCM];
    mon_set[SPB_MON_CFM] = cfm_fail_i && !s.mon_mask[SPB_MON_CFM];
    mon_set[SPB_MON_PFM] = pfm_fail_i && !s.mon_mask[SPB_MON_PFM];

    // failures are levels: one that persists re-arms its sticky bit after every read
    pll_sticky_nx = sticky_update(s.pll_sticky, pll_set,
        rd_hit(reg_rd_i, reg_addr_i, SPB_ADDR_PLL_IRQ_STAT));
    next_s.pll_sticky = pll_sticky_nx;
    next_s.mon_sticky = sticky_update(s.mon_sticky, mon_set,
        rd_hit(reg_rd_i, reg_addr_i, SPB_ADDR_MON_FAIL));

    // holdover only follows monitors that software left unmasked
    next_s.hold_req = (scm_fail_i && !s.hold_mask[SPB_MON_SCM]) ||
                      (cfm_fail_i && !s.hold_mask[SPB_MON_CFM]) ||
                      (pfm_fail_i && !s.hold_mask[SPB_MON_PFM]);

    // next sticky value feeds the interrupt, so a clearing read
    // releases the pin without one stale cycle
    next_s.irq_n = !((ref_fail_i && s.ref_irq_mask[0]) ||
                     (|(pll_sticky_nx & s.pll_irq_mask)));

    // read data: one cycle after the strobe
    // live status is taken at the read edge; sticky bytes show the value before clearing
    rd_byte = 8'h00;
    case (reg_addr_i)
      SPB_ADDR_IDENT: rd_byte = {s.rst_done, SPB_CHIP_REV, SPB_CHIP_ID};
      SPB_ADDR_REF_IRQ_STAT: rd_byte = {7'h00, ref_fail_i};
      SPB_ADDR_PLL_IRQ_STAT: rd_byte = s.pll_sticky;
      SPB_ADDR_MON_FAIL: rd_byte = s.mon_sticky;
      SPB_ADDR_REF_IRQ_MASK: rd_byte = s.ref_irq_mask;
      SPB_ADDR_PLL_IRQ_MASK: rd_byte = s.pll_irq_mask;
      SPB_ADDR_MON_FAIL_MASK: rd_byte = s.mon_mask;
      SPB_ADDR_FREQ_DETECT: rd_byte = freq_detected_i;
      SPB_ADDR_LOOP_BW: rd_byte = s.loop_bw;
      SPB_ADDR_HOLD_MASK: rd_byte = s.hold_mask;
      SPB_ADDR_LOCK_STAT: begin
        rd_byte[SPB_STAT_LOCK] = pll_locked_i;
        rd_byte[SPB_STAT_HOLD] = pll_holdover_i;
      end
      SPB_ADDR_PHASE_LOW: rd_byte = s.phase[7:0];
      SPB_ADDR_PHASE_MID: rd_byte = s.phase_shadow[15:8];
      SPB_ADDR_PHASE_HIGH: rd_byte = {2'h0, s.phase_shadow[21:16]};
      SPB_ADDR_SYNTH_EN: rd_byte = s.synth_en;
      SPB_ADDR_SYNTH_RUN: rd_byte = s.synth_run;
      SPB_ADDR_SYNTH_FREQ: rd_byte = s.synth_freq;
      SPB_ADDR_SYNTH_COARSE: rd_byte = s.synth_coarse;
      SPB_ADDR_SYNTH_FINE: rd_byte = s.synth_fine;
      SPB_ADDR_DIFF_EN: rd_byte = s.diff_en;
      SPB_ADDR_DIFF_FREQ: rd_byte = s.diff_freq;
      SPB_ADDR_SRC_MODE: rd_byte = s.src_mode;
      SPB_ADDR_MULT_LOW: rd_byte = s.mult[7:0];
      SPB_ADDR_MULT_HIGH: rd_byte = {2'h0, s.mult_shadow[13:8]};
      SPB_ADDR_SCM_LOW: rd_byte = s.scm_low;
      default: rd_byte = 8'h00;
    endcase
    next_s.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      next_s.rdata = rd_byte;
    end

    // reading the low byte freezes the whole value for the later bytes
    // upper bytes read without a fresh low-byte read return the older snapshot
    if (rd_hit(reg_rd_i, reg_addr_i, SPB_ADDR_PHASE_LOW)) begin
      next_s.phase_shadow = s.phase;
    end
    if (rd_hit(reg_rd_i, reg_addr_i, SPB_ADDR_MULT_LOW)) begin
      next_s.mult_shadow = s.mult;
    end

    // writes; read-only and reserved offsets fall through untouched
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_REF_IRQ_MASK)) begin
      next_s.ref_irq_mask = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_PLL_IRQ_MASK)) begin
      next_s.pll_irq_mask = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_MON_FAIL_MASK)) begin
      next_s.mon_mask = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_LOOP_BW)) begin
      next_s.loop_bw = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_HOLD_MASK)) begin
      next_s.hold_mask = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_PHASE_LOW)) begin
      next_s.phase_stage[7:0] = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_PHASE_MID)) begin
      next_s.phase_stage[15:8] = reg_wdata_i;
    end
    // a lone top-byte write reuses whatever was staged last
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_PHASE_HIGH)) begin
      next_s.phase = {reg_wdata_i[5:0], s.phase_stage};
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SYNTH_EN)) begin
      next_s.synth_en = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SYNTH_RUN)) begin
      next_s.synth_run = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SYNTH_FREQ)) begin
      next_s.synth_freq = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SYNTH_COARSE)) begin
      next_s.synth_coarse = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SYNTH_FINE)) begin
      next_s.synth_fine = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_DIFF_EN)) begin
      next_s.diff_en = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_DIFF_FREQ)) begin
      next_s.diff_freq = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SRC_MODE)) begin
      next_s.src_mode = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_MULT_LOW)) begin
      next_s.mult_stage = reg_wdata_i;
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_MULT_HIGH)) begin
      next_s.mult = {reg_wdata_i[5:0], s.mult_stage};
    end
    if (wr_hit(reg_wr_i, reg_addr_i, SPB_ADDR_SCM_LOW)) begin
      next_s.scm_low = reg_wdata_i;
    end
  end

  // the whole state leaves reset together, two edges after the pin
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= SPB_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // every pin is a copy of registered state, so no input reaches an output directly
  assign reg_rdata_o = s.rdata;
  assign reg_rvalid_o = s.rvalid;
  assign irq_n_o = s.irq_n;
  assign holdover_req_o = s.hold_req;
  assign loop_bandwidth_o = s.loop_bw;
  assign frame_phase_offset_o = s.phase;
  assign synth_block_enable_o = s.synth_en;
  assign synth_run_o = s.synth_run;
  assign synth_freq_o = s.synth_freq;
  assign synth_phase_coarse_o = s.synth_coarse;
  assign synth_phase_fine_o = s.synth_fine;
  assign diff_out_enable_o = s.diff_en;
  assign diff_out_freq_o = s.diff_freq;
  assign freq_source_mode_o = s.src_mode;
  assign custom_a_multiplier_o = s.mult;
  assign custom_a_single_cycle_low_o = s.scm_low;

endmodule : spb_reg_bank
`default_nettype wire

// File: tb/spb_reg_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spb_reg_bank_monitor
  import spb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic ref_fail_i,
  input wire logic [7:0] freq_detected_i,
  input wire logic pll_locked_i,
  input wire logic pll_holdover_i,
  input wire logic [7:0] loop_bandwidth_o,
  input wire logic [21:0] frame_phase_offset_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rd(logic [6:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_wr(logic [6:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  a_read_answer: assert property (1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after strobe");
  a_ident_value: assert property (s_rd(SPB_ADDR_IDENT) |=>
    reg_rdata_o == {1'b1, SPB_CHIP_REV, SPB_CHIP_ID})
    else $error("identity read wrong");
  a_reserved_zero: assert property (s_rd(7'h01) |=> reg_rdata_o == 8'h00)
    else $error("reserved read not zero");
  a_freq_status: assert property (s_rd(SPB_ADDR_FREQ_DETECT) |=>
    reg_rdata_o == $past(freq_detected_i))
    else $error("detected frequency read wrong");
  a_lock_status: assert property (s_rd(SPB_ADDR_LOCK_STAT) |=>
    reg_rdata_o == {6'h00, $past(pll_holdover_i), $past(pll_locked_i)})
    else $error("lock status read wrong");
  a_ref_status: assert property (s_rd(SPB_ADDR_REF_IRQ_STAT) |=>
    reg_rdata_o == {7'h00, $past(ref_fail_i)})
    else $error("reference failure read wrong");
  a_bw_write: assert property (s_wr(SPB_ADDR_LOOP_BW) |=>
    loop_bandwidth_o == $past(reg_wdata_i))
    else $error("bandwidth write not applied");
  a_phase_commit: assert property (!(reg_wr_i && reg_addr_i == SPB_ADDR_PHASE_HIGH) |=>
    $stable(frame_phase_offset_o))
    else $error("phase offset changed without top byte write");
endmodule : spb_reg_bank_monitor
bind spb_reg_bank spb_reg_bank_monitor spb_reg_bank_monitor_i (.sys_clk_i, .nrst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
  .ref_fail_i, .freq_detected_i, .pll_locked_i, .pll_holdover_i, .loop_bandwidth_o,
  .frame_phase_offset_o);
`default_nettype wire

// File: tb/spb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spb_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 7'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one byte per call; address and data are scrambled once released
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(negedge sys_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge sys_clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    ok = rvalid_i;
    d = rdata_i;
  endtask : rd
endmodule : spb_host_model
`default_nettype wire

// File: tb/test_spb_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_spb_reg_bank;
  import spb_pkg::*;
  logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, ref_fail_i, scm_fail_i;
  logic cfm_fail_i, pfm_fail_i, pll_locked_i, pll_holdover_i, irq_n_o, holdover_req_o, ok;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, freq_detected_i, loop_bandwidth_o, rv;
  logic [7:0] synth_block_enable_o, synth_run_o, synth_freq_o, synth_phase_coarse_o;
  logic [7:0] synth_phase_fine_o, diff_out_enable_o, diff_out_freq_o, freq_source_mode_o;
  logic [7:0] custom_a_single_cycle_low_o;
  logic [21:0] frame_phase_offset_o;
  logic [13:0] custom_a_multiplier_o;
  logic [6:0] cfg [14] = '{7'h09, 7'h0A, 7'h0C, 7'h1D, 7'h21, 7'h50, 7'h51, 7'h52, 7'h53,
    7'h55, 7'h60, 7'h61, 7'h65, 7'h69};
  int err_count = 0;
  int check_count = 0;
  spb_reg_bank spb_reg_bank_i (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .ref_fail_i, .scm_fail_i, .cfm_fail_i,
    .pfm_fail_i, .freq_detected_i, .pll_locked_i, .pll_holdover_i, .irq_n_o,
    .holdover_req_o, .loop_bandwidth_o, .frame_phase_offset_o, .synth_block_enable_o,
    .synth_run_o, .synth_freq_o, .synth_phase_coarse_o, .synth_phase_fine_o,
    .diff_out_enable_o, .diff_out_freq_o, .freq_source_mode_o, .custom_a_multiplier_o,
    .custom_a_single_cycle_low_o);
  spb_host_model spb_host_model_i (.sys_clk_i, .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    spb_host_model_i.rd(a, rv, ok);
    chk(ok, 1'b1);
    chk(rv, e);
  endtask : rdc
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wait_n
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic t_ident;
    rdc(SPB_ADDR_LOOP_BW, SPB_RST_BYTE);
    spb_host_model_i.wr(SPB_ADDR_IDENT, 8'h00);
    rdc(SPB_ADDR_IDENT, {1'b1, SPB_CHIP_REV, SPB_CHIP_ID});
    spb_host_model_i.wr(7'h01, 8'h5A);
    rdc(7'h01, 8'h00);
    rdc(7'h7F, 8'h00);
    $display("test ident done");
  endtask : t_ident
  task automatic t_config;
    foreach (cfg[i]) spb_host_model_i.wr(cfg[i], {1'b1, cfg[i]});
    foreach (cfg[i]) rdc(cfg[i], {1'b1, cfg[i]});
    chk(loop_bandwidth_o, 8'h9D);
    chk(synth_block_enable_o, 8'hD0);
    chk(synth_run_o, 8'hD1);
    chk(synth_freq_o, 8'hD2);
    chk({synth_phase_coarse_o, synth_phase_fine_o}, 16'hD3D5);
    chk({diff_out_enable_o, diff_out_freq_o}, 16'hE0E1);
    chk(freq_source_mode_o, 8'hE5);
    chk(custom_a_single_cycle_low_o, 8'hE9);
    $display("test config done");
  endtask : t_config
  task automatic t_multi;
    spb_host_model_i.wr(SPB_ADDR_PHASE_LOW, 8'h11);
    spb_host_model_i.wr(SPB_ADDR_PHASE_MID, 8'h22);
    chk(frame_phase_offset_o, SPB_RST_PHASE);
    spb_host_model_i.wr(SPB_ADDR_PHASE_HIGH, 8'hFF);
    chk(frame_phase_offset_o, 22'h3F2211);
    rdc(SPB_ADDR_PHASE_LOW, 8'h11);
    spb_host_model_i.wr(SPB_ADDR_PHASE_LOW, 8'h33);
    spb_host_model_i.wr(SPB_ADDR_PHASE_MID, 8'h44);
    spb_host_model_i.wr(SPB_ADDR_PHASE_HIGH, 8'h01);
    rdc(SPB_ADDR_PHASE_MID, 8'h22);
    rdc(SPB_ADDR_PHASE_HIGH, 8'h3F);
    chk(frame_phase_offset_o, 22'h014433);
    spb_host_model_i.wr(SPB_ADDR_MULT_LOW, 8'h34);
    chk(custom_a_multiplier_o, SPB_RST_MULT);
    spb_host_model_i.wr(SPB_ADDR_MULT_HIGH, 8'hFF);
    chk(custom_a_multiplier_o, 14'h3F34);
    rdc(SPB_ADDR_MULT_LOW, 8'h34);
    rdc(SPB_ADDR_MULT_HIGH, 8'h3F);
    $display("test multi-byte done");
  endtask : t_multi
  task automatic t_status;
    spb_host_model_i.wr(SPB_ADDR_REF_IRQ_MASK, 8'h01);
    spb_host_model_i.wr(SPB_ADDR_MON_FAIL_MASK, 8'h02);
    spb_host_model_i.wr(SPB_ADDR_HOLD_MASK, 8'h06);
    rdc(SPB_ADDR_PLL_IRQ_STAT, 8'h00);
    ref_fail_i = 1'b1;
    freq_detected_i = 8'h5C;
    rdc(SPB_ADDR_REF_IRQ_STAT, 8'h01);
    chk(irq_n_o, 1'b0);
    spb_host_model_i.wr(SPB_ADDR_REF_IRQ_MASK, 8'h00);
    wait_n(1);
    chk(irq_n_o, 1'b1);
    rdc(SPB_ADDR_FREQ_DETECT, 8'h5C);
    ref_fail_i = 1'b0;
    spb_host_model_i.wr(SPB_ADDR_PLL_IRQ_MASK, 8'h01);
    pll_locked_i = 1'b1;
    wait_n(2);
    chk(irq_n_o, 1'b0);
    rdc(SPB_ADDR_LOCK_STAT, 8'h01);
    rdc(SPB_ADDR_PLL_IRQ_STAT, 8'h01);
    rdc(SPB_ADDR_PLL_IRQ_STAT, 8'h00);
    chk(irq_n_o, 1'b1);
    pll_locked_i = 1'b0;
    pll_holdover_i = 1'b1;
    rdc(SPB_ADDR_PLL_IRQ_STAT, 8'h06);
    rdc(SPB_ADDR_LOCK_STAT, 8'h02);
    scm_fail_i = 1'b1;
    cfm_fail_i = 1'b1;
    wait_n(2);
    chk(holdover_req_o, 1'b1);
    scm_fail_i = 1'b0;
    pfm_fail_i = 1'b1;
    wait_n(2);
    chk(holdover_req_o, 1'b0);
    rdc(SPB_ADDR_MON_FAIL, 8'h05);
    pfm_fail_i = 1'b0;
    rdc(SPB_ADDR_MON_FAIL, 8'h04);
    rdc(SPB_ADDR_MON_FAIL, 8'h00);
    $display("test status done");
  endtask : t_status
  initial begin
    {nrst_i, ref_fail_i, scm_fail_i, cfm_fail_i, pfm_fail_i} = 5'h00;
    {pll_locked_i, pll_holdover_i, freq_detected_i} = 10'h000;
    repeat (20) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_ident();
    t_config();
    t_multi();
    t_status();
    complete_run();
  end
  // guards against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    complete_run();
  end
endmodule : test_spb_reg_bank
`default_nettype wire
